// ---- hw/ipt_sequencer.v ----
// Instruction prefetch and timing sequencer: paces each instruction in
// machine states, places operand, prefetch and store accesses, and
// stretches memory states while the bus holds off ready.
// Assumes cmd* come from logic on clk; busReady and intRequest are pins.
`timescale 1ns/1ps
`include "ipt_timing_defs.vh"

module ipt_sequencer (
  input  wire        clk,
  input  wire        rst,
  input  wire        cmdStart,
  input  wire [4:0]  cmdClass,
  input  wire [1:0]  cmdSrcMode,
  input  wire [1:0]  cmdDstMode,
  input  wire [3:0]  cmdCount,
  input  wire [7:0]  cmdIdleReps,
  input  wire        cmdOption,
  input  wire        busReady,
  input  wire        intRequest,
  output reg         busy_reg,
  output reg         done_reg,
  output reg         cycleStartStrobe_reg,
  output reg         memCycle_reg,
  output reg         opcodeFetch_reg,
  output reg         resultStore_reg,
  output reg         waitState_reg,
  output reg         prefetchValid_reg,
  output reg         prefetchDiscard_reg,
  output reg         intSwitch_reg,
  output reg  [9:0]  stateCount_reg,
  output reg  [3:0]  accessCount_reg,
  output reg  [9:0]  waitCount_reg
);

  localparam [1:0] ST_BOOT = 2'h0;
  localparam [1:0] ST_IDLE = 2'h1;
  localparam [1:0] ST_RUN  = 2'h2;

  reg  [1:0] fsm_reg;
  reg  [1:0] phase_reg;
  reg  [9:0] stepIdx_reg;
  reg  [9:0] totalC_reg;
  reg  [3:0] totalM_reg;
  reg        hasStore_reg;
  reg        readyMeta_reg;
  reg        readySync_reg;
  reg        intMeta_reg;
  reg        intSync_reg;
  reg        restart_reg;

  // Base cost: {store, C[9:0], M[3:0]}
  function [14:0] baseCost;
    input [4:0] cls;
    input [3:0] cnt;
    input [7:0] reps;
    input       opt;
    begin
      case (cls)
        `IPT_CL_WORD_MOVE:  baseCost = {1'b1, `IPT_C_WORD_MOVE, `IPT_M_WORD_MOVE};
        `IPT_CL_TWO_OP:     baseCost = {1'b1, `IPT_C_TWO_OP, `IPT_M_TWO_OP};
        `IPT_CL_UMUL:       baseCost = {1'b1, `IPT_C_UMUL, `IPT_M_MUL};
        `IPT_CL_SMUL:       baseCost = {1'b1, `IPT_C_SMUL, `IPT_M_MUL};
        `IPT_CL_UDIV: begin
          // Option high means the overflow flag is set: early exit
          if (opt)
            baseCost = {1'b0, (cnt[0] ? `IPT_C_UDIV_LONG : `IPT_C_UDIV_SHORT),
                        `IPT_M_UDIV_EARLY};
          else
            baseCost = {1'b1, `IPT_C_UDIV_FULL, `IPT_M_UDIV_FULL};
        end
        `IPT_CL_DADD:       baseCost = {1'b1, `IPT_C_DOUBLE, `IPT_M_DADD};
        `IPT_CL_DSUB:       baseCost = {1'b1, `IPT_C_DOUBLE, `IPT_M_DSUB};
        `IPT_CL_SER_OUT: begin
          if (cnt == 4'h0)
            baseCost = {1'b0, `IPT_C_SEROUT_ZERO, `IPT_M_SERIAL};
          else
            baseCost = {1'b0, `IPT_C_SEROUT_BASE + {5'h00, cnt, 1'b0},
                        `IPT_M_SERIAL};
        end
        `IPT_CL_SER_IN: begin
          if (cnt == 4'h0)
            baseCost = {1'b1, `IPT_C_SERIN_ZERO, `IPT_M_SERIAL};
          else if (cnt == `IPT_SER_CNT_EIGHT)
            baseCost = {1'b1, `IPT_C_SERIN_EIGHT, `IPT_M_SERIN_MID};
          else
            baseCost = {1'b1, `IPT_C_SERIN_BASE + {6'h00, cnt},
                        (cnt < `IPT_SER_CNT_EIGHT) ? `IPT_M_SERIN_MID
                                                   : `IPT_M_SERIAL};
        end
        `IPT_CL_IDLE:
          baseCost = {1'b0, `IPT_C_NINE + {1'b0, reps, 1'b0}, `IPT_M_ONE};
        `IPT_CL_EXTERNAL:   baseCost = {1'b0, `IPT_C_NINE, `IPT_M_ONE};
        `IPT_CL_CTX_RETURN:
          baseCost = {1'b0, (opt ? `IPT_C_CTX_RET_IN : `IPT_C_NINE),
                      `IPT_M_CTX_RET};
        `IPT_CL_CTX_BRANCH: baseCost = {1'b0, `IPT_C_CTX_BRANCH, `IPT_M_SIX};
        `IPT_CL_XOP_TRAP:   baseCost = {1'b0, `IPT_C_XOP, `IPT_M_XOP};
        `IPT_CL_JUMP:       baseCost = {1'b0, `IPT_C_JUMP, `IPT_M_ONE};
        `IPT_CL_BIT_IO:     baseCost = {1'b0, `IPT_C_BIT_IO, `IPT_M_TWO};
        `IPT_CL_TEST_MEM:   baseCost = {1'b1, `IPT_C_TEST_MEM, `IPT_M_SERIAL};
        `IPT_CL_UNDEF_AP:   baseCost = {1'b0, `IPT_C_UNDEF_AP, `IPT_M_UNDEF_AP};
        `IPT_CL_FAR_PREFIX: baseCost = {1'b0, `IPT_C_FAR_PREFIX, `IPT_M_ONE};
        `IPT_CL_RESET_FN:   baseCost = {1'b0, `IPT_C_SWITCH, `IPT_M_SIX};
        `IPT_CL_INT_SWITCH: baseCost = {1'b0, `IPT_C_SWITCH, `IPT_M_SIX};
        default:            baseCost = {1'b0, `IPT_C_JUMP, `IPT_M_ONE};
      endcase
    end
  endfunction

  // Autoincrement and indexed modes each cost one state and one access
  function modeExtra;
    input [1:0] mode;
    begin
      modeExtra = (mode == `IPT_MODE_AUTOINC) || (mode == `IPT_MODE_INDEXED);
    end
  endfunction

  // Only classes with operand fields pay for addressing modes
  function usesSrc;
    input [4:0] cls;
    begin
      usesSrc = (cls <= `IPT_CL_BIT_IO) && (cls != `IPT_CL_IDLE) &&
                (cls != `IPT_CL_EXTERNAL) && (cls != `IPT_CL_CTX_RETURN) &&
                (cls != `IPT_CL_JUMP) || (cls == `IPT_CL_TEST_MEM) ||
                (cls == `IPT_CL_FAR_PREFIX);
    end
  endfunction

  function usesDst;
    input [4:0] cls;
    begin
      usesDst = (cls <= `IPT_CL_TWO_OP) || (cls == `IPT_CL_DADD) ||
                (cls == `IPT_CL_DSUB) || (cls == `IPT_CL_BIT_IO);
    end
  endfunction

  wire [14:0] cmdCost  = baseCost(cmdClass, cmdCount, cmdIdleReps, cmdOption);
  wire        srcAdd   = usesSrc(cmdClass) & modeExtra(cmdSrcMode);
  wire        dstAdd   = usesDst(cmdClass) & modeExtra(cmdDstMode);
  wire [1:0]  modeSum  = {1'b0, srcAdd} + {1'b0, dstAdd};
  wire [9:0]  cmdC     = cmdCost[13:4] + {8'h00, modeSum};
  wire [3:0]  cmdM     = cmdCost[3:0] + {2'h0, modeSum};
  wire [14:0] swCost   = baseCost(`IPT_CL_INT_SWITCH, 4'h0, 8'h00, 1'b0);
  wire [14:0] rstCost  = baseCost(`IPT_CL_RESET_FN, 4'h0, 8'h00, 1'b0);

  // Access placement: operand accesses first, then prefetch, then store
  wire [3:0]  opsAcc    = totalM_reg - 4'h1 - {3'h0, hasStore_reg};
  wire [9:0]  lastStep  = totalC_reg - 10'h001;
  wire [9:0]  fetchStep = lastStep - {9'h000, hasStore_reg};
  wire        inRun     = (fsm_reg == ST_RUN);
  wire        isFetch   = inRun && (stepIdx_reg == fetchStep);
  wire        isStore   = inRun && hasStore_reg && (stepIdx_reg == lastStep);
  wire        isOperand = inRun && (stepIdx_reg < {6'h00, opsAcc});
  wire        isMem     = isOperand || isFetch || isStore;
  wire        stateEnd  = inRun && (phase_reg == `IPT_PHASE_LAST);
  wire        holdWait  = stateEnd && isMem && !readySync_reg;
  wire        lastEnd   = stateEnd && !holdWait && (stepIdx_reg == lastStep);
  wire        takeInt   = lastEnd && intSync_reg && !intSwitch_reg;

  // Pins cross into clk through two flops before anything reads them
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      readyMeta_reg <= 1'b0;
      readySync_reg <= 1'b0;
      intMeta_reg   <= 1'b0;
      intSync_reg   <= 1'b0;
    end else begin
      readyMeta_reg <= busReady;
      readySync_reg <= readyMeta_reg;
      intMeta_reg   <= intRequest;
      intSync_reg   <= intMeta_reg;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      fsm_reg              <= ST_BOOT;
      phase_reg            <= 2'h0;
      stepIdx_reg          <= 10'h000;
      totalC_reg           <= 10'h000;
      totalM_reg           <= 4'h0;
      hasStore_reg         <= 1'b0;
      busy_reg             <= 1'b1;
      done_reg             <= 1'b0;
      cycleStartStrobe_reg <= 1'b0;
      prefetchValid_reg    <= 1'b0;
      prefetchDiscard_reg  <= 1'b0;
      intSwitch_reg        <= 1'b0;
      stateCount_reg       <= 10'h000;
      accessCount_reg      <= 4'h0;
      waitCount_reg        <= 10'h000;
      restart_reg          <= 1'b0;
    end else begin
      done_reg            <= 1'b0;
      prefetchDiscard_reg <= 1'b0;
      restart_reg         <= 1'b0;
      case (fsm_reg)
        ST_BOOT: begin
          // Reset function runs its own sequence before any command
          fsm_reg              <= ST_RUN;
          totalC_reg           <= rstCost[13:4];
          totalM_reg           <= rstCost[3:0];
          hasStore_reg         <= rstCost[14];
          stepIdx_reg          <= 10'h000;
          phase_reg            <= 2'h0;
          intSwitch_reg        <= 1'b1;
          cycleStartStrobe_reg <= ~cycleStartStrobe_reg;
        end
        ST_IDLE: begin
          if (cmdStart) begin
            fsm_reg              <= ST_RUN;
            busy_reg             <= 1'b1;
            totalC_reg           <= cmdC;
            totalM_reg           <= cmdM;
            hasStore_reg         <= cmdCost[14];
            stepIdx_reg          <= 10'h000;
            phase_reg            <= 2'h0;
            intSwitch_reg        <= 1'b0;
            // The held opcode is consumed by the instruction now starting
            prefetchValid_reg    <= 1'b0;
            stateCount_reg       <= 10'h000;
            accessCount_reg      <= 4'h0;
            waitCount_reg        <= 10'h000;
            cycleStartStrobe_reg <= ~cycleStartStrobe_reg;
          end
        end
        ST_RUN: begin
          if (!stateEnd) begin
            phase_reg <= phase_reg + 2'h1;
            // Switch counters restart one clock after done, no state has ended yet
            if (restart_reg) begin
              stateCount_reg  <= 10'h000;
              accessCount_reg <= 4'h0;
              waitCount_reg   <= 10'h000;
            end
          end else if (holdWait) begin
            // Frozen state: one extra machine state, no new cycle start
            phase_reg     <= 2'h0;
            waitCount_reg <= waitCount_reg + 10'h001;
          end else begin
            phase_reg      <= 2'h0;
            stateCount_reg <= stateCount_reg + 10'h001;
            if (isMem)
              accessCount_reg <= accessCount_reg + 4'h1;
            if (isFetch)
              prefetchValid_reg <= 1'b1;
            if (takeInt) begin
              // An interrupt is the one event that throws the opcode away
              prefetchValid_reg    <= 1'b0;
              prefetchDiscard_reg  <= 1'b1;
              done_reg             <= 1'b1;
              intSwitch_reg        <= 1'b1;
              totalC_reg           <= swCost[13:4];
              totalM_reg           <= swCost[3:0];
              hasStore_reg         <= swCost[14];
              stepIdx_reg          <= 10'h000;
              // Counters show the interrupted instruction's totals with done
              restart_reg          <= 1'b1;
              cycleStartStrobe_reg <= ~cycleStartStrobe_reg;
            end else if (lastEnd) begin
              fsm_reg  <= ST_IDLE;
              busy_reg <= 1'b0;
              done_reg <= 1'b1;
            end else begin
              stepIdx_reg          <= stepIdx_reg + 10'h001;
              cycleStartStrobe_reg <= ~cycleStartStrobe_reg;
            end
          end
        end
        default: begin
          fsm_reg  <= ST_IDLE;
          busy_reg <= 1'b0;
        end
      endcase
    end
  end

  // Bus phase flags are registered, so they trail the state by one clock
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      memCycle_reg    <= 1'b0;
      opcodeFetch_reg <= 1'b0;
      resultStore_reg <= 1'b0;
      waitState_reg   <= 1'b0;
    end else begin
      memCycle_reg    <= isMem;
      opcodeFetch_reg <= isFetch;
      resultStore_reg <= isStore;
      waitState_reg   <= holdWait;
    end
  end

endmodule // ipt_sequencer

// ---- hw/ipt_timing_defs.vh ----
// Constants for the instruction prefetch and timing sequencer.
// Included by ipt_sequencer.v; holds definitions only.
`ifndef IPT_TIMING_DEFS_VH
`define IPT_TIMING_DEFS_VH

// Input clock periods per machine state
`define IPT_CLKS_PER_STATE 3'h4
`define IPT_PHASE_LAST     2'h3

// Instruction class codes
`define IPT_CL_WORD_MOVE   5'h00
`define IPT_CL_TWO_OP      5'h01
`define IPT_CL_UMUL        5'h02
`define IPT_CL_SMUL        5'h03
`define IPT_CL_UDIV        5'h04
`define IPT_CL_DADD        5'h05
`define IPT_CL_DSUB        5'h06
`define IPT_CL_SER_OUT     5'h07
`define IPT_CL_SER_IN      5'h08
`define IPT_CL_IDLE        5'h09
`define IPT_CL_EXTERNAL    5'h0a
`define IPT_CL_CTX_RETURN  5'h0b
`define IPT_CL_CTX_BRANCH  5'h0c
`define IPT_CL_XOP_TRAP    5'h0d
`define IPT_CL_JUMP        5'h0e
`define IPT_CL_BIT_IO      5'h0f
`define IPT_CL_TEST_MEM    5'h10
`define IPT_CL_UNDEF_AP    5'h11
`define IPT_CL_FAR_PREFIX  5'h12
`define IPT_CL_RESET_FN    5'h13
`define IPT_CL_INT_SWITCH  5'h14

// Addressing modes
`define IPT_MODE_REG       2'h0
`define IPT_MODE_IND       2'h1
`define IPT_MODE_INDEXED   2'h2
`define IPT_MODE_AUTOINC   2'h3

// Base state counts (C) and access counts (M)
`define IPT_C_WORD_MOVE    10'h003
`define IPT_M_WORD_MOVE    4'h3
`define IPT_C_TWO_OP       10'h004
`define IPT_M_TWO_OP       4'h4
`define IPT_C_UMUL         10'h017
`define IPT_C_SMUL         10'h019
`define IPT_M_MUL          4'h5
`define IPT_C_UDIV_SHORT   10'h006
`define IPT_C_UDIV_LONG    10'h00a
`define IPT_M_UDIV_EARLY   4'h4
`define IPT_C_UDIV_FULL    10'h01e
`define IPT_M_UDIV_FULL    4'h6
`define IPT_C_DOUBLE       10'h00c
`define IPT_M_DADD         4'h8
`define IPT_M_DSUB         4'h7
`define IPT_C_SEROUT_ZERO  10'h028
`define IPT_C_SEROUT_BASE  10'h008
`define IPT_M_SERIAL       4'h3
`define IPT_C_SERIN_ZERO   10'h02b
`define IPT_C_SERIN_EIGHT  10'h01b
`define IPT_C_SERIN_BASE   10'h014
`define IPT_M_SERIN_MID    4'h4
`define IPT_SER_CNT_EIGHT  4'h8
`define IPT_C_NINE         10'h009
`define IPT_M_ONE          4'h1
`define IPT_C_CTX_RET_IN   10'h007
`define IPT_M_CTX_RET      4'h4
`define IPT_C_CTX_BRANCH   10'h00a
`define IPT_M_SIX          4'h6
`define IPT_C_XOP          10'h00e
`define IPT_M_XOP          4'h7
`define IPT_C_JUMP         10'h003
`define IPT_C_BIT_IO       10'h007
`define IPT_M_TWO          4'h2
`define IPT_C_TEST_MEM     10'h01a
`define IPT_C_UNDEF_AP     10'h015
`define IPT_M_UNDEF_AP     4'h8
`define IPT_C_FAR_PREFIX   10'h001
`define IPT_C_SWITCH       10'h00d

`endif

// ---- verif/ipt_bus_model.sv ----
// Memory and I/O bus partner: answers at once, or holds ready off.
// Assumes memCycle and strobe are the sequencer's registered flags.
`timescale 1ns/1ps
module ipt_bus_model (
  input  wire clk,
  input  wire rst,
  input  wire memCycle,
  input  wire strobe,
  input  wire slow,
  output wire busReady
);
  reg strobeSeen_reg;
  reg fresh_reg;
  wire fresh = strobe != strobeSeen_reg;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      strobeSeen_reg <= 1'b0;
      fresh_reg      <= 1'b0;
    end else begin
      strobeSeen_reg <= strobe;
      fresh_reg      <= fresh;
    end
  end
  // Ready is off only in the first two clocks of a state while the trailing memCycle is set, so the
  // synchroniser sees a low sample at the state's end once per access: a uniform one wait
  assign busReady = !(slow && memCycle && (fresh || fresh_reg));
endmodule // ipt_bus_model

// ---- verif/ipt_sequencer_asserts.sv ----
// Concurrent checks on the timing sequencer's ports.
// Bound to every ipt_sequencer instance; one clock, reset active high.
`timescale 1ns/1ps
module ipt_sequencer_asserts (
  input logic clk,
  input logic rst,
  input logic cmdStart,
  input logic busy_reg,
  input logic done_reg,
  input logic cycleStartStrobe_reg,
  input logic memCycle_reg,
  input logic opcodeFetch_reg,
  input logic resultStore_reg,
  input logic waitState_reg,
  input logic prefetchValid_reg,
  input logic prefetchDiscard_reg,
  input logic intSwitch_reg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_int_end;
    done_reg && prefetchDiscard_reg;
  endsequence
  sequence s_switch_run;
    busy_reg [*8] ##0 intSwitch_reg;
  endsequence
  property p_accept;
    cmdStart && !busy_reg |=> busy_reg [*4];
  endproperty
  a_accept: assert property (p_accept) else $error("instruction shorter than one state");
  property p_done;
    done_reg |-> $past(busy_reg) ##1 !done_reg;
  endproperty
  a_done: assert property (p_done) else $error("done not a single pulse inside busy");
  property p_state_len;
    $changed(cycleStartStrobe_reg) |=> $stable(cycleStartStrobe_reg) [*3];
  endproperty
  a_state_len: assert property (p_state_len) else $error("state shorter than four clocks");
  property p_wait_strobe;
    waitState_reg |-> cycleStartStrobe_reg == $past(cycleStartStrobe_reg, 2);
  endproperty
  a_wait_strobe: assert property (p_wait_strobe) else $error("strobe toggled on a wait");
  property p_wait_mem;
    waitState_reg |-> memCycle_reg ##1 (!waitState_reg) [*3];
  endproperty
  a_wait_mem: assert property (p_wait_mem) else $error("wait outside a memory state");
  property p_fetch_mem;
    opcodeFetch_reg |-> memCycle_reg;
  endproperty
  a_fetch_mem: assert property (p_fetch_mem) else $error("prefetch not on the memory bus");
  property p_store_order;
    $rose(resultStore_reg) |-> $past(opcodeFetch_reg);
  endproperty
  a_store_order: assert property (p_store_order) else $error("store before prefetch");
  property p_kept;
    $fell(prefetchValid_reg) |-> $past(cmdStart && !busy_reg) || prefetchDiscard_reg
      || $past(prefetchDiscard_reg);
  endproperty
  a_kept: assert property (p_kept) else $error("prefetched opcode lost");
  property p_int_switch;
    prefetchDiscard_reg |-> s_int_end ##1 s_switch_run;
  endproperty
  a_int_switch: assert property (p_int_switch) else $error("interrupt switch not started");
endmodule // ipt_sequencer_asserts

bind ipt_sequencer ipt_sequencer_asserts i_chk (
  .clk(clk), .rst(rst), .cmdStart(cmdStart), .busy_reg(busy_reg), .done_reg(done_reg),
  .cycleStartStrobe_reg(cycleStartStrobe_reg), .memCycle_reg(memCycle_reg),
  .opcodeFetch_reg(opcodeFetch_reg), .resultStore_reg(resultStore_reg),
  .waitState_reg(waitState_reg), .prefetchValid_reg(prefetchValid_reg),
  .prefetchDiscard_reg(prefetchDiscard_reg), .intSwitch_reg(intSwitch_reg));

// ---- verif/ipt_sequencer_tb.sv ----
// Self-checking bench for the instruction timing sequencer.
// Assumes the bus model sits on the ready pin and the checker is bound.
`timescale 1ns/1ps
`include "ipt_timing_defs.vh"
module ipt_sequencer_tb;
  localparam integer LIM = 3000;
  reg        clk, rst, cmdStart, cmdOption, intRequest, slow;
  reg  [4:0] cmdClass;
  reg  [1:0] cmdSrcMode, cmdDstMode, wCur;
  reg  [3:0] cmdCount;
  reg  [7:0] cmdIdleReps;
  wire       busReady, busy_reg, done_reg, cycleStartStrobe_reg, memCycle_reg;
  wire       opcodeFetch_reg, resultStore_reg, waitState_reg, prefetchValid_reg;
  wire       prefetchDiscard_reg, intSwitch_reg;
  wire [9:0] stateCount_reg, waitCount_reg;
  wire [3:0] accessCount_reg;
  integer    err_count, num_checks, n;

  ipt_sequencer i_dut (.clk(clk), .rst(rst), .cmdStart(cmdStart), .cmdClass(cmdClass),
    .cmdSrcMode(cmdSrcMode), .cmdDstMode(cmdDstMode), .cmdCount(cmdCount),
    .cmdIdleReps(cmdIdleReps), .cmdOption(cmdOption), .busReady(busReady),
    .intRequest(intRequest), .busy_reg(busy_reg), .done_reg(done_reg),
    .cycleStartStrobe_reg(cycleStartStrobe_reg), .memCycle_reg(memCycle_reg),
    .opcodeFetch_reg(opcodeFetch_reg), .resultStore_reg(resultStore_reg),
    .waitState_reg(waitState_reg), .prefetchValid_reg(prefetchValid_reg),
    .prefetchDiscard_reg(prefetchDiscard_reg), .intSwitch_reg(intSwitch_reg),
    .stateCount_reg(stateCount_reg), .accessCount_reg(accessCount_reg),
    .waitCount_reg(waitCount_reg));
  ipt_bus_model i_bus (.clk(clk), .rst(rst), .memCycle(memCycle_reg),
    .strobe(cycleStartStrobe_reg), .slow(slow), .busReady(busReady));

  task summarize;
    begin
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  // Wide enough for the longest idle sequence counted in clocks
  task chkNum(input string what, input [15:0] exp, input [15:0] got);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("wrong value %s expected %0d seen %0d", what, exp, got);
      end
    end
  endtask
  task chkBit(input string what, input exp, input got);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("wrong value %s expected %b seen %b", what, exp, got);
      end
    end
  endtask
  task tick;
    begin
      @(posedge clk);
      #1;
    end
  endtask
  // Waits for done (sel 1) or idle (sel 0); running out ends the run
  task waitLevel(input sel, output integer k);
    begin
      k = 0;
      while ((sel ? done_reg : !busy_reg) !== 1'b1 && k < LIM) begin
        tick;
        k = k + 1;
      end
      if (k >= LIM) begin
        err_count = err_count + 1;
        $display("wrong value wait expected event seen timeout");
        summarize;
      end
    end
  endtask
  task run(input [4:0] cl, input [1:0] sm, input [1:0] dm, input [3:0] cn, input [7:0] rp,
           input op, input irq, input [9:0] c, input [3:0] m);
    integer k;
    begin
      waitLevel(1'b0, k);
      cmdClass    = cl;
      cmdSrcMode  = sm;
      cmdDstMode  = dm;
      cmdCount    = cn;
      cmdIdleReps = rp;
      cmdOption   = op;
      cmdStart    = 1'b1;
      tick;
      cmdStart    = 1'b0;
      intRequest  = irq;
      waitLevel(1'b1, k);
      chkNum("clocks", 16'(4 * (c + wCur * m)), 16'(k));
      chkNum("states", c, stateCount_reg);
      chkNum("accesses", {6'h00, m}, {6'h00, accessCount_reg});
      chkNum("waits", 16'(wCur * m), waitCount_reg);
      chkBit("discard", irq, prefetchDiscard_reg);
      tick;
      chkBit("prefetch held", ~irq, prefetchValid_reg);
    end
  endtask
  task go(input [4:0] cl, input [3:0] cn, input [7:0] rp, input op, input [9:0] c,
          input [3:0] m);
    begin
      run(cl, `IPT_MODE_REG, `IPT_MODE_REG, cn, rp, op, 1'b0, c, m);
    end
  endtask

  task test_reset;
    begin
      waitLevel(1'b1, n);
      chkNum("reset states", 10'h00d, stateCount_reg);
      chkNum("reset accesses", 10'h006, {6'h00, accessCount_reg});
      chkBit("reset switch", 1'b1, intSwitch_reg);
      $display("test reset finished");
    end
  endtask
  task test_arith;
    begin
      go(`IPT_CL_JUMP, 4'h0, 8'h00, 1'b0, 10'h003, 4'h1);
      go(`IPT_CL_WORD_MOVE, 4'h0, 8'h00, 1'b0, 10'h003, 4'h3);
      go(`IPT_CL_TWO_OP, 4'h0, 8'h00, 1'b0, 10'h004, 4'h4);
      go(`IPT_CL_UMUL, 4'h0, 8'h00, 1'b0, 10'h017, 4'h5);
      go(`IPT_CL_SMUL, 4'h0, 8'h00, 1'b0, 10'h019, 4'h5);
      go(`IPT_CL_UDIV, 4'h0, 8'h00, 1'b1, 10'h006, 4'h4);
      go(`IPT_CL_UDIV, 4'h1, 8'h00, 1'b1, 10'h00a, 4'h4);
      go(`IPT_CL_UDIV, 4'h0, 8'h00, 1'b0, 10'h01e, 4'h6);
      go(`IPT_CL_DADD, 4'h0, 8'h00, 1'b0, 10'h00c, 4'h8);
      go(`IPT_CL_DSUB, 4'h0, 8'h00, 1'b0, 10'h00c, 4'h7);
      $display("test arith finished");
    end
  endtask
  task test_misc;
    begin
      go(`IPT_CL_SER_OUT, 4'h0, 8'h00, 1'b0, 10'h028, 4'h3);
      go(`IPT_CL_SER_OUT, 4'hf, 8'h00, 1'b0, 10'h026, 4'h3);
      go(`IPT_CL_SER_IN, 4'h0, 8'h00, 1'b0, 10'h02b, 4'h3);
      go(`IPT_CL_SER_IN, 4'h8, 8'h00, 1'b0, 10'h01b, 4'h4);
      go(`IPT_CL_SER_IN, 4'h3, 8'h00, 1'b0, 10'h017, 4'h4);
      go(`IPT_CL_SER_IN, 4'hf, 8'h00, 1'b0, 10'h023, 4'h3);
      go(`IPT_CL_IDLE, 4'h0, 8'hff, 1'b0, 10'h207, 4'h1);
      go(`IPT_CL_EXTERNAL, 4'h0, 8'h00, 1'b0, 10'h009, 4'h1);
      go(`IPT_CL_CTX_RETURN, 4'h0, 8'h00, 1'b1, 10'h007, 4'h4);
      go(`IPT_CL_CTX_RETURN, 4'h0, 8'h00, 1'b0, 10'h009, 4'h4);
      go(`IPT_CL_CTX_BRANCH, 4'h0, 8'h00, 1'b0, 10'h00a, 4'h6);
      go(`IPT_CL_XOP_TRAP, 4'h0, 8'h00, 1'b0, 10'h00e, 4'h7);
      go(`IPT_CL_BIT_IO, 4'h0, 8'h00, 1'b0, 10'h007, 4'h2);
      go(`IPT_CL_TEST_MEM, 4'h0, 8'h00, 1'b0, 10'h01a, 4'h3);
      go(`IPT_CL_UNDEF_AP, 4'h0, 8'h00, 1'b0, 10'h015, 4'h8);
      $display("test misc finished");
    end
  endtask
  task test_modes;
    begin
      run(`IPT_CL_TWO_OP, `IPT_MODE_AUTOINC, `IPT_MODE_INDEXED, 4'h0, 8'h00, 1'b0, 1'b0,
          10'h006, 4'h6);
      run(`IPT_CL_WORD_MOVE, `IPT_MODE_IND, `IPT_MODE_IND, 4'h0, 8'h00, 1'b0, 1'b0,
          10'h003, 4'h3);
      run(`IPT_CL_FAR_PREFIX, `IPT_MODE_AUTOINC, `IPT_MODE_REG, 4'h0, 8'h00, 1'b0, 1'b0,
          10'h002, 4'h2);
      $display("test modes finished");
    end
  endtask
  task test_waits;
    begin
      slow = 1'b1;
      wCur = 2'h1;
      go(`IPT_CL_WORD_MOVE, 4'h0, 8'h00, 1'b0, 10'h003, 4'h3);
      go(`IPT_CL_UMUL, 4'h0, 8'h00, 1'b0, 10'h017, 4'h5);
      slow = 1'b0;
      wCur = 2'h0;
      $display("test waits finished");
    end
  endtask
  task test_interrupt;
    begin
      run(`IPT_CL_JUMP, `IPT_MODE_REG, `IPT_MODE_REG, 4'h0, 8'h00, 1'b0, 1'b1,
          10'h003, 4'h1);
      intRequest = 1'b0;
      cmdClass   = `IPT_CL_JUMP;
      cmdStart   = 1'b1;
      tick;
      cmdStart   = 1'b0;
      waitLevel(1'b1, n);
      chkNum("switch states", 10'h00d, stateCount_reg);
      chkNum("switch accesses", 10'h006, {6'h00, accessCount_reg});
      chkBit("switch flag", 1'b1, intSwitch_reg);
      tick;
      chkBit("busy after switch", 1'b0, busy_reg);
      go(`IPT_CL_JUMP, 4'h0, 8'h00, 1'b0, 10'h003, 4'h1);
      $display("test interrupt finished");
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    rst         = 1'b1;
    cmdStart    = 1'b0;
    cmdOption   = 1'b0;
    intRequest  = 1'b0;
    slow        = 1'b0;
    wCur        = 2'h0;
    cmdClass    = 5'h00;
    cmdSrcMode  = 2'h0;
    cmdDstMode  = 2'h0;
    cmdCount    = 4'h0;
    cmdIdleReps = 8'h00;
    err_count   = 0;
    num_checks  = 0;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    test_reset;
    test_arith;
    test_misc;
    test_modes;
    test_waits;
    test_interrupt;
    summarize;
  end
endmodule // ipt_sequencer_tb
